/* File: bcsir_regs.svh */
// Offsets, fields, reset values and counts of the channel 2 bank.
`ifndef BCSIR_REGS_SVH
`define BCSIR_REGS_SVH

// Register offsets on the serial port.
`define BCSIR_OFF_SEL_MODES   8'h2C
`define BCSIR_OFF_CODE_A      8'h2D
`define BCSIR_OFF_CODE_B      8'h2E
`define BCSIR_OFF_PART_ID     8'h48
`define BCSIR_OFF_REV_VAR     8'h49
`define BCSIR_OFF_CUST_CODE   8'h4A
`define BCSIR_OFF_CFG_REV     8'h4B

// Field positions in the select and mode register.
`define BCSIR_SEL_BIT         4
`define BCSIR_MODE_B_MSB      3
`define BCSIR_MODE_B_LSB      2
`define BCSIR_MODE_A_MSB      1
`define BCSIR_MODE_A_LSB      0

// Raw mode field encodings.
`define BCSIR_MODE_RAW_PFM    2'h0
`define BCSIR_MODE_RAW_AUTO   2'h3

// Legal voltage code window: 0.30 V to 1.90 V in 10 mV steps.
`define BCSIR_CODE_MIN        8'h1E
`define BCSIR_CODE_MAX        8'hBE

// Reset values used when no strap value is loaded.
`define BCSIR_RST_SEL         1'h0
`define BCSIR_RST_MODE        2'h3
`define BCSIR_RST_CODE        8'h64

// Strap profile taken when the strap pin reads high.
`define BCSIR_STRAP1_SEL      1'h1
`define BCSIR_STRAP1_MODE_A   2'h3
`define BCSIR_STRAP1_MODE_B   2'h1
`define BCSIR_STRAP1_CODE_A   8'h64
`define BCSIR_STRAP1_CODE_B   8'h64

// Edges after release before the strap is sampled.
`define BCSIR_STRAP_SETTLE    2'h2

// Reset value of the synchroniser: enable, strap, data, clock.
`define BCSIR_SYNC_RST        4'h3

`endif

/* File: bcsir_pkg.sv */
// Types shared by the channel 2 setpoint bank.
package bcsir_pkg;

  // Converter operating mode after decoding a raw mode field.
  typedef enum logic [1:0] {
    BCSIR_MODE_PFM,
    BCSIR_MODE_PWM,
    BCSIR_MODE_AUTO
  } bcsir_mode_t;

  // Serial port byte engine states.
  typedef enum logic [3:0] {
    BCSIR_ST_IDLE,
    BCSIR_ST_ADDR,
    BCSIR_ST_ADDR_ACK,
    BCSIR_ST_PTR,
    BCSIR_ST_PTR_ACK,
    BCSIR_ST_WR,
    BCSIR_ST_WR_ACK,
    BCSIR_ST_RD,
    BCSIR_ST_RD_ACK
  } bcsir_bus_state_t;

endpackage : bcsir_pkg

/* File: bcsir_sync.sv */
// Two flip-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
module bcsir_sync #(
  parameter int         WIDTH     = 4,
  parameter logic [3:0] RESET_VAL = 4'h0
) (
  // Clock and reset.
  input  wire logic             core_clk_i,
  input  wire logic             rst_b_i,
  // Asynchronous pins and their synchronised copies.
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  genvar g;

  // Two flops per bit; only the second is read.
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      logic meta;
      always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          meta      <= RESET_VAL[g];
          sync_o[g] <= RESET_VAL[g];
        end else begin
          meta      <= async_i[g];
          sync_o[g] <= meta;
        end
      end
    end
  endgenerate

endmodule : bcsir_sync

/* File: bcsir_setpoint_eval.sv */
// Active setpoint select, mode decode and write range check.
`timescale 1ns/1ps
`include "bcsir_regs.svh"
module bcsir_setpoint_eval (
  // Stored setpoint state.
  input  wire logic               sel_i,
  input  wire logic [1:0]         mode_a_i,
  input  wire logic [1:0]         mode_b_i,
  input  wire logic [7:0]         code_a_i,
  input  wire logic [7:0]         code_b_i,
  // Candidate write data.
  input  wire logic [7:0]         wr_data_i,
  // Results.
  output logic      [7:0]         code_o,
  output bcsir_pkg::bcsir_mode_t  mode_o,
  output logic                    wr_in_range_o
);

  logic [1:0] raw_mode;

  // Setpoint select chooses the voltage and mode pair.
  always_comb begin
    code_o   = sel_i ? code_b_i : code_a_i;
    raw_mode = sel_i ? mode_b_i : mode_a_i;
  end

  // Mode decode: 0 PFM, 3 auto, else PWM.
  always_comb begin
    case (raw_mode)
      `BCSIR_MODE_RAW_PFM:  mode_o = bcsir_pkg::BCSIR_MODE_PFM;
      `BCSIR_MODE_RAW_AUTO: mode_o = bcsir_pkg::BCSIR_MODE_AUTO;
      default:              mode_o = bcsir_pkg::BCSIR_MODE_PWM;
    endcase
  end

  // Codes outside 0.30 V to 1.90 V are not accepted.
  assign wr_in_range_o = (wr_data_i >= `BCSIR_CODE_MIN) &&
                         (wr_data_i <= `BCSIR_CODE_MAX);

endmodule : bcsir_setpoint_eval

/* File: bcsir_regs.sv */
// Channel 2 setpoint and identity register bank behind a two-wire serial port.
//
// Functional notes
// - Select bit picks set A or B.
// - Mode field: 0 PFM, 1-2 PWM, 3 auto.
// - Strap enable loads setpoint fields from strap pin.
// - Set A code linear, 10 mV per step.
// - Set B code uses the same scale.
// - Both codes default to one volt, 0x64.
// - Out-of-range code writes keep old value.
// - Part identifier at 0x48, writes ignored.
// - 0x49: mask revision high, variant low.
// - Customer code 0x4A, config revision 0x4B.
// - Select and mode register sits at 0x2C.
`timescale 1ns/1ps
`include "bcsir_regs.svh"
module bcsir_regs #(
  parameter logic [6:0] DEV_ADDR          = 7'h2A,  // Bus address, arbitrary.
  parameter logic [7:0] PART_IDENTIFIER   = 8'hA5,  // Arbitrary value.
  parameter logic [3:0] MASK_REVISION     = 4'h1,   // Arbitrary value.
  parameter logic [3:0] CHIP_VARIANT_CODE = 4'h2,   // Arbitrary value.
  parameter logic [7:0] CUSTOMER_CODE     = 8'h3C,  // Arbitrary value.
  parameter logic [7:0] PROG_PROGRAMMED_CONFIG_REVISION   = 8'h01   // Arbitrary value.
) (
  // Clock and reset.
  input  wire logic               core_clk_i,
  input  wire logic               rst_b_i,
  // Serial port pins; data is open drain.
  input  wire logic               scl_i,
  input  wire logic               sda_i,
  output logic                    sda_o,
  output logic                    sda_oe_b_o,
  // Start-up straps.
  input  wire logic               configuration_strap_pin_i,
  input  wire logic               strap_load_enable_i,
  // Active setpoint towards the converter.
  output logic                    setpoint_select_bit_o,
  output logic      [7:0]         active_voltage_code_o,
  output bcsir_pkg::bcsir_mode_t  active_mode_o,
  output logic                    init_done_o
);

  // Synchronised pins and their delayed copies.
  logic [3:0] pins_sync;
  logic       scl_s;
  logic       sda_s;
  logic       strap_s;
  logic       strap_en_s;
  logic       scl_d;
  logic       sda_d;

  // Start-up state.
  logic [1:0] init_cnt;
  logic [1:0] next_init_cnt;
  logic       init_done;
  logic       next_init_done;
  logic       load_strap;

  // Setpoint registers.
  logic       setpoint_select_bit;
  logic [1:0] set_a_operation_field;
  logic [1:0] set_b_operation_field;
  logic [7:0] set_a_voltage_code;
  logic [7:0] set_b_voltage_code;
  logic       next_setpoint_select_bit;
  logic [1:0] next_set_a_operation_field;
  logic [1:0] next_set_b_operation_field;
  logic [7:0] next_set_a_voltage_code;
  logic [7:0] next_set_b_voltage_code;

  // Serial engine state.
  bcsir_pkg::bcsir_bus_state_t state;
  bcsir_pkg::bcsir_bus_state_t next_state;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [7:0] shift_reg;
  logic [7:0] next_shift_reg;
  logic [7:0] ptr;
  logic [7:0] next_ptr;
  logic       rw;
  logic       next_rw;
  logic       pull_low;
  logic       next_pull_low;
  logic       wr_en;

  // Bus events and read data.
  logic       ev_start;
  logic       ev_stop;
  logic       ev_rise;
  logic       ev_fall;
  logic [7:0] rd_cur;
  logic [7:0] rd_inc;
  logic [7:0] ptr_inc;

  // Evaluated setpoint.
  logic [7:0]             sel_code;
  bcsir_pkg::bcsir_mode_t sel_mode;
  logic                   wr_in_range;

  // Pins pass two flops first.
  bcsir_sync #(
    .WIDTH     (4),
    .RESET_VAL (`BCSIR_SYNC_RST)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .async_i    ({strap_load_enable_i, configuration_strap_pin_i, sda_i, scl_i}),
    .sync_o     (pins_sync)
  );

  assign scl_s      = pins_sync[0];
  assign sda_s      = pins_sync[1];
  assign strap_s    = pins_sync[2];
  assign strap_en_s = pins_sync[3];

  // Select, decode and range check.
  bcsir_setpoint_eval u_eval (
    .sel_i         (setpoint_select_bit),
    .mode_a_i      (set_a_operation_field),
    .mode_b_i      (set_b_operation_field),
    .code_a_i      (set_a_voltage_code),
    .code_b_i      (set_b_voltage_code),
    .wr_data_i     (shift_reg),
    .code_o        (sel_code),
    .mode_o        (sel_mode),
    .wr_in_range_o (wr_in_range)
  );

  // Read map; reserved and unmapped offsets read as zero.
  function automatic logic [7:0] read_reg(input logic [7:0] addr);
    logic [7:0] data;
    data = 8'h00;
    case (addr)
      `BCSIR_OFF_SEL_MODES: data = {3'h0, setpoint_select_bit, set_b_operation_field,
                                    set_a_operation_field};
      `BCSIR_OFF_CODE_A:    data = set_a_voltage_code;
      `BCSIR_OFF_CODE_B:    data = set_b_voltage_code;
      `BCSIR_OFF_PART_ID:   data = PART_IDENTIFIER;
      `BCSIR_OFF_REV_VAR:   data = {MASK_REVISION, CHIP_VARIANT_CODE};
      `BCSIR_OFF_CUST_CODE: data = CUSTOMER_CODE;
      `BCSIR_OFF_CFG_REV:   data = PROG_PROGRAMMED_CONFIG_REVISION;
      default:              data = 8'h00;
    endcase
    return data;
  endfunction : read_reg

  assign ptr_inc = ptr + 8'h01;
  assign rd_cur  = read_reg(ptr);
  assign rd_inc  = read_reg(ptr_inc);

  // Bus edges and conditions.
  assign ev_start = init_done & scl_s & scl_d & sda_d & ~sda_s;
  assign ev_stop  = scl_s & scl_d & ~sda_d & sda_s;
  assign ev_rise  = scl_s & ~scl_d;
  assign ev_fall  = ~scl_s & scl_d;

  // Delayed lines for edge detection.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Start-up: wait for the synchronised straps, load once.
  always_comb begin
    next_init_cnt  = init_cnt;
    next_init_done = init_done;
    load_strap     = 1'b0;
    if (!init_done) begin
      next_init_cnt = init_cnt + 2'h1;
      if (init_cnt == `BCSIR_STRAP_SETTLE) begin
        next_init_done = 1'b1;
        load_strap     = strap_en_s;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      init_cnt  <= 2'h0;
      init_done <= 1'b0;
    end else begin
      init_cnt  <= next_init_cnt;
      init_done <= next_init_done;
    end
  end

  // Serial byte engine: address, then pointer and write bytes, or read bytes.
  always_comb begin
    next_state     = state;
    next_bit_cnt   = bit_cnt;
    next_shift_reg = shift_reg;
    next_ptr       = ptr;
    next_rw        = rw;
    next_pull_low  = pull_low;
    wr_en          = 1'b0;
    if (ev_start) begin
      next_state    = bcsir_pkg::BCSIR_ST_ADDR;
      next_bit_cnt  = 4'h0;
      next_pull_low = 1'b0;
    end else if (ev_stop) begin
      next_state    = bcsir_pkg::BCSIR_ST_IDLE;
      next_pull_low = 1'b0;
    end else begin
      case (state)
        bcsir_pkg::BCSIR_ST_IDLE: begin
          next_pull_low = 1'b0;
        end
        bcsir_pkg::BCSIR_ST_ADDR,
        bcsir_pkg::BCSIR_ST_PTR,
        bcsir_pkg::BCSIR_ST_WR: begin
          if (ev_rise && bit_cnt != 4'h8) begin
            next_shift_reg = {shift_reg[6:0], sda_s};
            next_bit_cnt   = bit_cnt + 4'h1;
          end else if (ev_fall && bit_cnt == 4'h8) begin
            next_pull_low = 1'b1;
            if (state == bcsir_pkg::BCSIR_ST_ADDR) begin
              if (shift_reg[7:1] == DEV_ADDR) begin
                next_rw    = shift_reg[0];
                next_state = bcsir_pkg::BCSIR_ST_ADDR_ACK;
              end else begin
                next_pull_low = 1'b0;
                next_state    = bcsir_pkg::BCSIR_ST_IDLE;
              end
            end else if (state == bcsir_pkg::BCSIR_ST_PTR) begin
              next_ptr   = shift_reg;
              next_state = bcsir_pkg::BCSIR_ST_PTR_ACK;
            end else begin
              wr_en      = 1'b1;
              next_state = bcsir_pkg::BCSIR_ST_WR_ACK;
            end
          end
        end
        bcsir_pkg::BCSIR_ST_ADDR_ACK: begin
          if (ev_fall) begin
            next_bit_cnt = 4'h0;
            if (rw) begin
              next_shift_reg = rd_cur;
              next_pull_low  = ~rd_cur[7];
              next_state     = bcsir_pkg::BCSIR_ST_RD;
            end else begin
              next_pull_low = 1'b0;
              next_state    = bcsir_pkg::BCSIR_ST_PTR;
            end
          end
        end
        bcsir_pkg::BCSIR_ST_PTR_ACK,
        bcsir_pkg::BCSIR_ST_WR_ACK: begin
          if (ev_fall) begin
            next_bit_cnt  = 4'h0;
            next_pull_low = 1'b0;
            next_state    = bcsir_pkg::BCSIR_ST_WR;
            if (state == bcsir_pkg::BCSIR_ST_WR_ACK) begin
              next_ptr = ptr_inc;
            end
          end
        end
        bcsir_pkg::BCSIR_ST_RD: begin
          if (ev_fall) begin
            if (bit_cnt == 4'h7) begin
              next_pull_low = 1'b0;
              next_state    = bcsir_pkg::BCSIR_ST_RD_ACK;
            end else begin
              next_shift_reg = {shift_reg[6:0], 1'b0};
              next_pull_low  = ~shift_reg[6];
              next_bit_cnt   = bit_cnt + 4'h1;
            end
          end
        end
        bcsir_pkg::BCSIR_ST_RD_ACK: begin
          if (ev_rise) begin
            next_shift_reg = {shift_reg[7:1], sda_s};
          end else if (ev_fall) begin
            if (!shift_reg[0]) begin
              next_ptr       = ptr_inc;
              next_shift_reg = rd_inc;
              next_pull_low  = ~rd_inc[7];
              next_bit_cnt   = 4'h0;
              next_state     = bcsir_pkg::BCSIR_ST_RD;
            end else begin
              next_state = bcsir_pkg::BCSIR_ST_IDLE;
            end
          end
        end
        default: begin
          next_pull_low = 1'b0;
          next_state    = bcsir_pkg::BCSIR_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state     <= bcsir_pkg::BCSIR_ST_IDLE;
      bit_cnt   <= 4'h0;
      shift_reg <= 8'h00;
      ptr       <= 8'h00;
      rw        <= 1'b0;
      pull_low  <= 1'b0;
    end else begin
      state     <= next_state;
      bit_cnt   <= next_bit_cnt;
      shift_reg <= next_shift_reg;
      ptr       <= next_ptr;
      rw        <= next_rw;
      pull_low  <= next_pull_low;
    end
  end

  // Setpoint registers: strap load at start-up, then host writes.
  always_comb begin
    next_setpoint_select_bit   = setpoint_select_bit;
    next_set_a_operation_field = set_a_operation_field;
    next_set_b_operation_field = set_b_operation_field;
    next_set_a_voltage_code    = set_a_voltage_code;
    next_set_b_voltage_code    = set_b_voltage_code;
    if (load_strap) begin
      if (strap_s) begin
        next_setpoint_select_bit   = `BCSIR_STRAP1_SEL;
        next_set_a_operation_field = `BCSIR_STRAP1_MODE_A;
        next_set_b_operation_field = `BCSIR_STRAP1_MODE_B;
        next_set_a_voltage_code    = `BCSIR_STRAP1_CODE_A;
        next_set_b_voltage_code    = `BCSIR_STRAP1_CODE_B;
      end else begin
        next_setpoint_select_bit   = `BCSIR_RST_SEL;
        next_set_a_operation_field = `BCSIR_RST_MODE;
        next_set_b_operation_field = `BCSIR_RST_MODE;
        next_set_a_voltage_code    = `BCSIR_RST_CODE;
        next_set_b_voltage_code    = `BCSIR_RST_CODE;
      end
    end else if (wr_en) begin
      case (ptr)
        `BCSIR_OFF_SEL_MODES: begin
          next_setpoint_select_bit   = shift_reg[`BCSIR_SEL_BIT];
          next_set_b_operation_field = shift_reg[`BCSIR_MODE_B_MSB:`BCSIR_MODE_B_LSB];
          next_set_a_operation_field = shift_reg[`BCSIR_MODE_A_MSB:`BCSIR_MODE_A_LSB];
        end
        `BCSIR_OFF_CODE_A: begin
          if (wr_in_range) begin
            next_set_a_voltage_code = shift_reg;
          end
        end
        `BCSIR_OFF_CODE_B: begin
          if (wr_in_range) begin
            next_set_b_voltage_code = shift_reg;
          end
        end
        default: begin
          next_setpoint_select_bit = setpoint_select_bit;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      setpoint_select_bit   <= `BCSIR_RST_SEL;
      set_a_operation_field <= `BCSIR_RST_MODE;
      set_b_operation_field <= `BCSIR_RST_MODE;
      set_a_voltage_code    <= `BCSIR_RST_CODE;
      set_b_voltage_code    <= `BCSIR_RST_CODE;
    end else begin
      setpoint_select_bit   <= next_setpoint_select_bit;
      set_a_operation_field <= next_set_a_operation_field;
      set_b_operation_field <= next_set_b_operation_field;
      set_a_voltage_code    <= next_set_a_voltage_code;
      set_b_voltage_code    <= next_set_b_voltage_code;
    end
  end

  // Registered copy of the active setpoint.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      setpoint_select_bit_o <= `BCSIR_RST_SEL;
      active_voltage_code_o <= `BCSIR_RST_CODE;
      active_mode_o         <= bcsir_pkg::BCSIR_MODE_AUTO;
    end else begin
      setpoint_select_bit_o <= setpoint_select_bit;
      active_voltage_code_o <= sel_code;
      active_mode_o         <= sel_mode;
    end
  end

  // Open drain data: the line is only ever pulled low.
  assign sda_o       = 1'b0;
  assign sda_oe_b_o  = ~pull_low;
  assign init_done_o = init_done;

endmodule : bcsir_regs

/* File: bcsir_host_model.sv */
// Two-wire bus master model.
`timescale 1ns/1ps
module bcsir_host_model (
  // Core clock that paces the bus.
  input  wire logic core_clk_i,
  // Resolved level of the open-drain data wire.
  input  wire logic sda_wire_i,
  // Line drive; 1 releases to the pull-up.
  output logic      scl_o,
  output logic      sda_o
);
  localparam int GAP = 8;

  // Both lines start released.
  initial begin
    scl_o = 1'h1;
    sda_o = 1'h1;
  end

  // Third of a bit, ending just off the clock edge.
  task automatic gap();
    repeat (GAP) @(posedge core_clk_i);
    #2;
  endtask : gap

  // Start: data falls while clock is high.
  task automatic start_cond();
    sda_o = 1'h1;
    gap();
    scl_o = 1'h1;
    gap();
    sda_o = 1'h0;
    gap();
    scl_o = 1'h0;
  endtask : start_cond

  // Stop: data rises while the clock is high.
  task automatic stop_cond();
    gap();
    sda_o = 1'h0;
    gap();
    scl_o = 1'h1;
    gap();
    sda_o = 1'h1;
    gap();
  endtask : stop_cond

  // One bit: data set while low, wire sampled while high.
  task automatic bit_x(input logic b, output logic r);
    gap();
    sda_o = b;
    gap();
    scl_o = 1'h1;
    gap();
    r = sda_wire_i;
    scl_o = 1'h0;
  endtask : bit_x

  // Eight bits MSB first, then the acknowledge.
  task automatic byte_x(input logic [7:0] d, input logic last, output logic [7:0] r,
                        output logic ack_b);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r[i]);
    end
    bit_x(last, ack_b);
  endtask : byte_x

  // Write: address, pointer, one data byte.
  task automatic wr(input logic [6:0] addr, input logic [7:0] ptr, input logic [7:0] d,
                    output logic nak);
    logic [7:0] r;
    logic [2:0] n;
    start_cond();
    byte_x({addr, 1'h0}, 1'h1, r, n[0]);
    byte_x(ptr, 1'h1, r, n[1]);
    byte_x(d, 1'h1, r, n[2]);
    stop_cond();
    nak = |n;
  endtask : wr

  // Read: pointer, repeated start, one byte, NACK.
  task automatic rd(input logic [6:0] addr, input logic [7:0] ptr, output logic [7:0] d,
                    output logic nak);
    logic [7:0] r;
    logic [2:0] n;
    start_cond();
    byte_x({addr, 1'h0}, 1'h1, r, n[0]);
    byte_x(ptr, 1'h1, r, n[1]);
    start_cond();
    byte_x({addr, 1'h1}, 1'h1, r, n[2]);
    byte_x(8'hFF, 1'h1, d, r[0]);
    stop_cond();
    nak = |n;
  endtask : rd
endmodule : bcsir_host_model

/* File: bcsir_regs_properties.sv */
// Concurrent checks on the ports of the channel 2 setpoint bank.
`timescale 1ns/1ps
`include "bcsir_regs.svh"
module bcsir_regs_properties (
  // Clock and reset.
  input wire logic                   core_clk_i,
  input wire logic                   rst_b_i,
  // Serial clock and start-up straps.
  input wire logic                   scl_i,
  input wire logic                   configuration_strap_pin_i,
  input wire logic                   strap_load_enable_i,
  // Active setpoint outputs.
  input wire logic                   setpoint_select_bit_o,
  input wire logic [7:0]             active_voltage_code_o,
  input wire bcsir_pkg::bcsir_mode_t active_mode_o,
  input wire logic                   init_done_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // Reset values hold on release.
  property p_reset_values;
    $rose(rst_b_i) |-> !setpoint_select_bit_o && active_voltage_code_o == `BCSIR_RST_CODE
      && active_mode_o == bcsir_pkg::BCSIR_MODE_AUTO;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

  // Code stays in its window.
  property p_code_range;
    active_voltage_code_o >= `BCSIR_CODE_MIN && active_voltage_code_o <= `BCSIR_CODE_MAX;
  endproperty
  a_code_range: assert property (p_code_range) else $error("code out of range");

  // Only decoded modes appear.
  property p_mode_legal;
    2'(active_mode_o) != 2'h3;
  endproperty
  a_mode_legal: assert property (p_mode_legal) else $error("mode encoding illegal");

  // Start-up ends in bounded time.
  property p_init_bound;
    $rose(rst_b_i) |-> !init_done_o ##1 !init_done_o ##[1:2] init_done_o;
  endproperty
  a_init_bound: assert property (p_init_bound) else $error("start-up length wrong");

  // Start-up happens once per reset.
  property p_init_hold;
    init_done_o |=> init_done_o;
  endproperty
  a_init_hold: assert property (p_init_hold) else $error("start-up flag fell");

  // High strap loads set B, forced PWM.
  property p_strap_b;
    $rose(init_done_o) && strap_load_enable_i && configuration_strap_pin_i |-> ##[0:1]
      (setpoint_select_bit_o && active_mode_o == bcsir_pkg::BCSIR_MODE_PWM
       && active_voltage_code_o == `BCSIR_STRAP1_CODE_B);
  endproperty
  a_strap_b: assert property (p_strap_b) else $error("strap profile not loaded");

  // Defaults survive with loading off.
  property p_strap_off;
    $rose(init_done_o) && !strap_load_enable_i |-> ##1
      (!setpoint_select_bit_o && active_voltage_code_o == `BCSIR_RST_CODE);
  endproperty
  a_strap_off: assert property (p_strap_off) else $error("defaults lost");

  // Select moves only by a write, SCL low.
  property p_sel_by_host;
    init_done_o && $past(init_done_o, 2) && $changed(setpoint_select_bit_o) |-> !scl_i;
  endproperty
  a_sel_by_host: assert property (p_sel_by_host) else $error("select moved idle");
endmodule : bcsir_regs_properties

/* File: bcsir_regs_test.sv */
// Self-checking bench of the channel 2 setpoint and identity bank.
`timescale 1ns/1ps
`include "bcsir_regs.svh"
module bcsir_regs_test;
  localparam logic [6:0] ADDR = 7'h2A;
  // Identity bytes, arbitrary values.
  localparam logic [7:0] ID [4] = '{8'h5A, 8'h79, 8'hC3, 8'h0E};
  localparam logic [7:0] BND [4] = '{8'h1D, 8'h1E, 8'hBE, 8'hBF};
  logic                   core_clk_i = 1'h0;
  logic                   rst_b = 1'h0;
  logic                   strap_pin = 1'h1;
  logic                   strap_en = 1'h1;
  logic                   scl_w, host_sda, sda_w, sda_o, sda_oe_b_o, sel_o, init_done_o;
  logic [7:0]             code_o, ca, cb, v, rd_v;
  logic [1:0]             ma, mb;
  logic                   sel, nak;
  bcsir_pkg::bcsir_mode_t mode_o;
  logic [31:0]            seed = 32'h5;
  int                     num_errors = 0;
  int                     n_checks = 0;

  // Clock and the open-drain data wire with its pull-up.
  always #10 core_clk_i = ~core_clk_i;
  assign sda_w = host_sda & (sda_oe_b_o | sda_o);

  bcsir_regs #(.DEV_ADDR(ADDR), .PART_IDENTIFIER(ID[0]), .MASK_REVISION(ID[1][7:4]),
    .CHIP_VARIANT_CODE(ID[1][3:0]), .CUSTOMER_CODE(ID[2]), .PROG_PROGRAMMED_CONFIG_REVISION(ID[3])) dut_u (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b), .scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_b_o(sda_oe_b_o), .configuration_strap_pin_i(strap_pin),
    .strap_load_enable_i(strap_en), .setpoint_select_bit_o(sel_o),
    .active_voltage_code_o(code_o), .active_mode_o(mode_o), .init_done_o(init_done_o));

  bcsir_host_model host_u (.core_clk_i(core_clk_i), .sda_wire_i(sda_w), .scl_o(scl_w),
    .sda_o(host_sda));

  // Xorshift source.
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // Expected mode decode.
  function automatic bcsir_pkg::bcsir_mode_t mode_of(input logic [1:0] raw);
    return raw == 2'h0 ? bcsir_pkg::BCSIR_MODE_PFM :
           raw == 2'h3 ? bcsir_pkg::BCSIR_MODE_AUTO : bcsir_pkg::BCSIR_MODE_PWM;
  endfunction : mode_of

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Accesses at the bank's address, all acknowledged.
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    host_u.wr(ADDR, ptr, d, nak);
    chk("write ack", 8'h0, {7'h0, nak});
  endtask : wr

  task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
    host_u.rd(ADDR, ptr, rd_v, nak);
    chk("read ack", 8'h0, {7'h0, nak});
    chk("read data", exp, rd_v);
  endtask : rd

  // Writes select and modes, tracking the expected fields.
  task automatic put_sel(input logic [7:0] d);
    wr(`BCSIR_OFF_SEL_MODES, d);
    sel = d[4];
    mb = d[3:2];
    ma = d[1:0];
  endtask : put_sel

  // Writes a code; out-of-window writes are dropped.
  task automatic put_code(input logic b, input logic [7:0] d);
    wr(b ? `BCSIR_OFF_CODE_B : `BCSIR_OFF_CODE_A, d);
    if (d >= `BCSIR_CODE_MIN && d <= `BCSIR_CODE_MAX) begin
      if (b) begin
        cb = d;
      end else begin
        ca = d;
      end
    end
  endtask : put_code

  // Checks the active outputs.
  task automatic outs();
    chk("select", {7'h0, sel}, {7'h0, sel_o});
    chk("code", sel ? cb : ca, code_o);
    chk("mode", {6'h0, mode_of(sel ? mb : ma)}, {6'h0, mode_o});
  endtask : outs

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // Straps, defaults, identity, fields, codes.
  initial begin
    repeat (12) @(posedge core_clk_i);
    #2;
    rst_b = 1'h1;
    repeat (10) @(posedge core_clk_i);
    {sel, ma, mb, ca, cb} = {1'h1, 2'h3, 2'h1, 8'h64, 8'h64};
    outs();
    rd(`BCSIR_OFF_SEL_MODES, 8'h17);
    @(posedge core_clk_i);
    #2;
    rst_b = 1'h0;
    strap_en = 1'h0;
    repeat (6) @(posedge core_clk_i);
    #2;
    rst_b = 1'h1;
    repeat (10) @(posedge core_clk_i);
    {sel, ma, mb} = {1'h0, 2'h3, 2'h3};
    outs();
    rd(`BCSIR_OFF_CODE_A, 8'h64);
    rd(`BCSIR_OFF_CODE_B, 8'h64);
    for (int i = 0; i < 4; i++) begin
      rd(8'(`BCSIR_OFF_PART_ID + i), ID[i]);
    end
    wr(`BCSIR_OFF_PART_ID, 8'(xs()));
    rd(`BCSIR_OFF_PART_ID, ID[0]);
    v = {3'h7, 5'(xs())};
    put_sel(v);
    rd(`BCSIR_OFF_SEL_MODES, {3'h0, v[4:0]});
    for (int s = 0; s < 2; s++) begin
      for (int m = 0; m < 4; m++) begin
        put_sel({3'h0, s[0], 2'(m), 2'(3 - m)});
        outs();
      end
    end
    for (int s = 0; s < 2; s++) begin
      put_sel({3'h0, s[0], 4'h6});
      for (int k = 0; k < 8; k++) begin
        v = k < 4 ? BND[k] : 8'(xs());
        put_code(s[0], v);
        outs();
      end
    end
    rd(`BCSIR_OFF_CODE_A, ca);
    rd(`BCSIR_OFF_CODE_B, cb);
    put_sel(8'h03);
    outs();
    host_u.wr(7'h2B, `BCSIR_OFF_SEL_MODES, 8'h10, nak);
    chk("foreign address nak", 8'h1, {7'h0, nak});
    outs();
    give_verdict();
  end

  // Watchdog.
  initial begin
    repeat (100000) @(posedge core_clk_i);
    num_errors++;
    give_verdict();
  end
endmodule : bcsir_regs_test

bind bcsir_regs bcsir_regs_properties chk_u (
  .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .scl_i(scl_i),
  .configuration_strap_pin_i(configuration_strap_pin_i),
  .strap_load_enable_i(strap_load_enable_i), .setpoint_select_bit_o(setpoint_select_bit_o),
  .active_voltage_code_o(active_voltage_code_o), .active_mode_o(active_mode_o),
  .init_done_o(init_done_o));
